// ### rtl/urp_defs.svh
`ifndef URP_DEFS_SVH
`define URP_DEFS_SVH
// Register byte offsets.
`define URP_PORT_OFF 8'h00
`define URP_STAT_OFF 8'h04
`define URP_MASK_OFF 8'h08
// Port register field positions.
`define URP_CONN_BIT 0
`define URP_CCHG_BIT 1
`define URP_EN_BIT 2
`define URP_ECHG_BIT 3
`define URP_DP_BIT 4
`define URP_DM_BIT 5
`define URP_RST_BIT 9
// Interrupt status bit positions.
`define URP_IRQ_CONN 0
`define URP_IRQ_FAULT 1
// Frame timing: 1 ms frame at 125 MHz, end-of-frame point 16 clocks (128 ns) early.
`define URP_FRAME_NS 1000000
`define URP_CLK_NS 8
`define URP_FRAME_CYC (`URP_FRAME_NS / `URP_CLK_NS)
`define URP_EOF2_CYC 16
`define URP_MASK_RST 2'h0
`endif

// ### rtl/urp_frame.sv
`include "urp_defs.svh"
module urp_frame (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_eof2
);
  import urp_pkg::*;
  localparam int FRAME = `URP_FRAME_CYC;
  logic [16:0] cnt_r;
  logic eof2_r;
  wire logic at_end = (cnt_r == 17'(FRAME - 1));
  wire logic at_eof2 = (cnt_r == 17'(FRAME - 1 - `URP_EOF2_CYC));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 17'h0_0000;
      eof2_r <= 1'b0;
    end else begin
      cnt_r <= at_end ? 17'h0_0000 : cnt_r + 17'h0_0001;
      eof2_r <= at_eof2;
    end
  end
  assign o_eof2 = eof2_r;
endmodule : urp_frame

// ### rtl/urp_pkg.sv
package urp_pkg;
  typedef struct packed {
    logic dm;
    logic dp;
    logic conn;
  } urp_line_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } urp_bus_t;
  typedef enum logic [2:0] {
    URP_OFF = 3'b001,
    URP_ON = 3'b010,
    URP_RESET = 3'b100
  } urp_state_t;
endpackage : urp_pkg

// ### rtl/urp_port.sv
// Chosen here: the strobed register port and the address map.
`include "urp_defs.svh"
module urp_port (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire urp_pkg::urp_line_t i_line,
  input wire logic i_busy,
  input wire logic i_fault,
  output logic o_port_en,
  output logic o_bus_reset,
  output logic o_irq
);
  import urp_pkg::*;
  urp_line_t line_s;
  logic eof2;
  urp_state_t st_r, st_nxt;
  logic conn_r, cchg_r, echg_r, rst_r;
  logic [1:0] lvl_r;
  logic [1:0] stat_r, mask_r;
  logic want_en_r;
  logic [15:0] rdata_r;
  logic irq_r;

  urp_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_line),
    .o_sync(line_s)
  );
  urp_frame u_frame (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_eof2(eof2)
  );

  wire logic wr_port = i_wr && (i_addr == `URP_PORT_OFF);
  wire logic wr_mask = i_wr && (i_addr == `URP_MASK_OFF);
  wire logic rd_stat = i_rd && (i_addr == `URP_STAT_OFF);
  wire logic conn_chg = line_s.conn != conn_r;
  wire logic disc = conn_chg && !line_s.conn;
  // A fault only counts at the end-of-frame point so a glitch mid-frame cannot drop the port.
  wire logic frame_fault = eof2 && i_fault;
  wire logic hw_drop = (st_r == URP_ON) && (disc || frame_fault);
  wire logic clr_cchg = wr_port && i_wdata[`URP_CCHG_BIT];
  wire logic clr_echg = wr_port && i_wdata[`URP_ECHG_BIT];
  wire logic [1:0] ev = {hw_drop, conn_chg};
  wire logic [15:0] port_word = {6'h00, rst_r, 1'b0, 1'b1, 1'b0, lvl_r, echg_r, st_r == URP_ON,
                                 cchg_r, conn_r};
  wire logic [15:0] rd_mux = (i_addr == `URP_PORT_OFF) ? port_word :
                             (i_addr == `URP_STAT_OFF) ? {14'h0000, stat_r} :
                             (i_addr == `URP_MASK_OFF) ? {14'h0000, mask_r} : 16'h0000;

  // Enable request is applied only when the bus is idle, so the bit lags a running transaction.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      URP_OFF: begin
        if (rst_r) st_nxt = URP_RESET;
        else if (want_en_r && !i_busy && line_s.conn) st_nxt = URP_ON;
      end
      URP_ON: begin
        if (rst_r) st_nxt = URP_RESET;
        else if (hw_drop) st_nxt = URP_OFF;
        else if (!want_en_r && !i_busy) st_nxt = URP_OFF;
      end
      URP_RESET: begin
        if (!rst_r) st_nxt = URP_OFF;
      end
      default: st_nxt = URP_OFF;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= URP_OFF;
      want_en_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (wr_port) begin
        want_en_r <= i_wdata[`URP_EN_BIT];
        rst_r <= i_wdata[`URP_RST_BIT];
      end else if (hw_drop || rst_r || !line_s.conn) begin
        // A request left pending while detached would let a later attach enable the port.
        want_en_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      conn_r <= 1'b0;
      cchg_r <= 1'b0;
      echg_r <= 1'b0;
      lvl_r <= 2'h0;
    end else begin
      conn_r <= line_s.conn;
      cchg_r <= conn_chg | (cchg_r & ~clr_cchg);
      echg_r <= hw_drop | (echg_r & ~clr_echg);
      if (eof2) lvl_r <= {line_s.dm, line_s.dp};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_r <= 2'h0;
      mask_r <= `URP_MASK_RST;
      rdata_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      stat_r <= ev | (stat_r & {2{~rd_stat}});
      if (wr_mask) mask_r <= i_wdata[1:0];
      rdata_r <= i_rd ? rd_mux : 16'h0000;
      irq_r <= |((ev | (stat_r & {2{~rd_stat}})) & mask_r);
    end
  end

  assign o_rdata = rdata_r;
  assign o_port_en = st_r[1];
  assign o_bus_reset = st_r[2];
  assign o_irq = irq_r;

  sequence drop_s;
    hw_drop;
  endsequence
  port_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    drop_s |=> !o_port_en && echg_r) else $error("fault did not disable");
  en_only_sw_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_port_en) |-> $past(want_en_r)) else $error("port enabled by hw");
  echg_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(echg_r) |-> $past(hw_drop)) else $error("enable change without drop");
  cchg_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
    conn_chg |=> cchg_r) else $error("connect change lost");
  cchg_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(cchg_r) |-> $past(clr_cchg)) else $error("connect flag cleared wrongly");
  lvl_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(eof2) |-> $stable(lvl_r)) else $error("levels moved mid frame");
  rst_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rst_r |=> !o_port_en) else $error("enabled during reset");
  conn_track_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> conn_r == $past(line_s.conn)) else $error("connect bit stale");
  busy_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_port_en && i_busy && !hw_drop && !rst_r) |=> o_port_en)
    else $error("disabled mid transaction");

  // Read accesses, one sequence per decoded window.
  sequence rd_port_s;
    i_rd && (i_addr == `URP_PORT_OFF);
  endsequence
  sequence rd_stat_s;
    i_rd && (i_addr == `URP_STAT_OFF);
  endsequence
  sequence rd_mask_s;
    i_rd && (i_addr == `URP_MASK_OFF);
  endsequence
  sequence rd_none_s;
    i_rd && (i_addr != `URP_PORT_OFF) && (i_addr != `URP_STAT_OFF) && (i_addr != `URP_MASK_OFF);
  endsequence
  sequence connect_edge_s;
    conn_chg;
  endsequence

  // Port word layout as software sees it.
  conn_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[`URP_CONN_BIT] == $past(conn_r))
    else $error("connect bit misread");
  cchg_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[`URP_CCHG_BIT] == $past(cchg_r))
    else $error("connect change misread");
  en_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[`URP_EN_BIT] == $past(o_port_en))
    else $error("enable bit misread");
  echg_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[`URP_ECHG_BIT] == $past(echg_r))
    else $error("enable change misread");
  dp_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[`URP_DP_BIT] == $past(lvl_r[0]))
    else $error("positive line misread");
  dm_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[`URP_DM_BIT] == $past(lvl_r[1]))
    else $error("negative line misread");
  rst_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[`URP_RST_BIT] == $past(rst_r))
    else $error("port reset bit misread");
  fixed_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_port_s |=> o_rdata[15:10] == 6'h00 && o_rdata[8:6] == 3'h2)
    else $error("fixed port bits wrong");
  stat_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_stat_s |=> o_rdata == {14'h0000, $past(stat_r)})
    else $error("status misread");
  mask_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_mask_s |=> o_rdata == {14'h0000, $past(mask_r)})
    else $error("mask misread");
  none_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_none_s |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read");

  // Line levels move only at the end-of-frame point and then follow the pins.
  lvl_eof2_a: assert property (@(posedge i_clk) disable iff (i_rst)
    eof2 |=> lvl_r[1] == $past(line_s.dm) && lvl_r[0] == $past(line_s.dp))
    else $error("levels not captured");
  eof2_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    eof2 |=> !eof2)
    else $error("frame point longer than a cycle");

  // Change flags: set by hardware, cleared only by a written one.
  cchg_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(conn_r) |-> cchg_r)
    else $error("connect edge without flag");
  cchg_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(cchg_r) |-> $past(conn_chg))
    else $error("connect flag set without change");
  cchg_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cchg_r && !clr_cchg |=> cchg_r)
    else $error("connect flag lost");
  cchg_w1c_a: assert property (@(posedge i_clk) disable iff (i_rst)
    clr_cchg && !conn_chg |=> !cchg_r)
    else $error("connect flag not cleared");
  echg_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    echg_r && !clr_echg |=> echg_r)
    else $error("enable flag lost");
  echg_w1c_a: assert property (@(posedge i_clk) disable iff (i_rst)
    clr_echg && !hw_drop |=> !echg_r)
    else $error("enable flag not cleared");
  echg_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !hw_drop && !echg_r |=> !echg_r)
    else $error("enable flag set by software");
  echg_was_on_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(echg_r) |-> $past(o_port_en))
    else $error("enable flag set while off");

  // Enable control: only a write asks, hardware only takes away.
  want_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(want_en_r) |-> $past(wr_port))
    else $error("enable request not from write");
  want_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_port |=> want_en_r == $past(i_wdata[`URP_EN_BIT]))
    else $error("enable write not taken");
  want_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    hw_drop && !wr_port |=> !want_en_r)
    else $error("request kept after fault");
  detach_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !line_s.conn && !wr_port |=> !want_en_r)
    else $error("request kept while detached");
  en_conn_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_port_en) |-> $past(line_s.conn))
    else $error("enabled while detached");
  detach_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !line_s.conn |=> !o_port_en)
    else $error("enabled after detach");
  disc_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    connect_edge_s ##0 (o_port_en && !line_s.conn) |=> !o_port_en && echg_r)
    else $error("disconnect did not drop");
  en_grant_a: assert property (@(posedge i_clk) disable iff (i_rst)
    want_en_r && line_s.conn && !i_busy && !rst_r && !o_bus_reset && !frame_fault |=> o_port_en)
    else $error("enable not applied when idle");
  dis_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_port_en && !want_en_r && !i_busy |=> !o_port_en)
    else $error("disable not applied when idle");
  state_hot_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot(st_r))
    else $error("state not one-hot");

  // Port reset drives the bus and keeps the port off.
  rst_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_port |=> rst_r == $past(i_wdata[`URP_RST_BIT]))
    else $error("reset bit write not taken");
  rst_enter_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rst_r |=> o_bus_reset)
    else $error("bus reset not driven");
  rst_exit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_bus_reset && !rst_r |=> !o_bus_reset && !o_port_en)
    else $error("bus reset not released");

  // Status and interrupt: a read clears, an event in the same cycle wins.
  stat_conn_a: assert property (@(posedge i_clk) disable iff (i_rst)
    connect_edge_s |=> stat_r[0])
    else $error("connect event not latched");
  stat_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    hw_drop |=> stat_r[1])
    else $error("drop event not latched");
  stat_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_stat && ev == 2'h0 |=> stat_r == 2'h0)
    else $error("status not cleared by read");
  mask_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_mask |=> mask_r == $past(i_wdata[1:0]))
    else $error("mask write not taken");
  irq_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_irq == |(stat_r & $past(mask_r)))
    else $error("interrupt level wrong");
  irq_masked_a: assert property (@(posedge i_clk) disable iff (i_rst)
    mask_r == 2'h0 |=> !o_irq)
    else $error("masked interrupt raised");
endmodule : urp_port

// ### rtl/urp_sync.sv
module urp_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire urp_pkg::urp_line_t i_async,
  output urp_pkg::urp_line_t o_sync
);
  import urp_pkg::*;
  urp_line_t meta_r;
  urp_line_t sync_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule : urp_sync

// ### verif/tb_top.sv
`include "urp_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import urp_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_busy = 1'b0;
  logic i_fault = 1'b0;
  logic attach = 1'b0;
  logic [15:0] o_rdata;
  logic o_port_en;
  logic o_bus_reset;
  logic o_irq;
  urp_line_t line;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  urp_dev i_dev (.i_attach(attach), .o_line(line));
  urp_port i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line(line), .i_busy(i_busy),
    .i_fault(i_fault), .o_port_en(o_port_en), .o_bus_reset(o_bus_reset), .o_irq(o_irq));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // The tests need well under a thousand cycles, so this only cuts a hang.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`URP_PORT_OFF, 16'h0080);
    rd(`URP_MASK_OFF, 16'h0000);
    rd(8'h10, 16'h0000);
    $display("test reset done");
    attach <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd(`URP_PORT_OFF, 16'h0083);
    wr(`URP_MASK_OFF, 16'h0003);
    chk(16'(o_irq), 16'h0001);
    rd(`URP_STAT_OFF, 16'h0001);
    repeat (2) @(posedge i_clk);
    #1;
    chk(16'(o_irq), 16'h0000);
    wr(`URP_PORT_OFF, 16'h0000);
    rd(`URP_PORT_OFF, 16'h0083);
    wr(`URP_PORT_OFF, 16'h0002);
    rd(`URP_PORT_OFF, 16'h0081);
    $display("test connect done");
    i_busy <= 1'b1;
    wr(`URP_PORT_OFF, 16'h0004);
    chk(16'(o_port_en), 16'h0000);
    rd(`URP_PORT_OFF, 16'h0081);
    i_busy <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk(16'(o_port_en), 16'h0001);
    rd(`URP_PORT_OFF, 16'h0085);
    i_fault <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    chk(16'(o_port_en), 16'h0001);
    i_fault <= 1'b0;
    wr(`URP_PORT_OFF, 16'h0000);
    rd(`URP_PORT_OFF, 16'h0081);
    $display("test enable done");
    wr(`URP_PORT_OFF, 16'h0004);
    wr(`URP_PORT_OFF, 16'h0204);
    chk(16'(o_bus_reset), 16'h0001);
    rd(`URP_PORT_OFF, 16'h0281);
    wr(`URP_PORT_OFF, 16'h0000);
    chk(16'(o_bus_reset), 16'h0000);
    $display("test port reset done");
    wr(`URP_PORT_OFF, 16'h0004);
    attach <= 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    chk(16'(o_port_en), 16'h0000);
    rd(`URP_PORT_OFF, 16'h008a);
    rd(`URP_STAT_OFF, 16'h0003);
    wr(`URP_PORT_OFF, 16'h000a);
    rd(`URP_PORT_OFF, 16'h0080);
    wr(`URP_PORT_OFF, 16'h0004);
    rd(`URP_PORT_OFF, 16'h0080);
    attach <= 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
    chk(16'(o_port_en), 16'h0000);
    rd(`URP_PORT_OFF, 16'h0083);
    $display("test disconnect done");
    finish_test();
  end
endmodule : tb_top

// ### verif/urp_dev.sv
module urp_dev (
  input wire logic i_attach,
  output urp_pkg::urp_line_t o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  import urp_pkg::*;
  // Detached lines sit on the pull-downs; an attached full-speed device idles in J.
  assign o_line = '{dm: 1'b0, dp: i_attach, conn: i_attach};
endmodule : urp_dev
